// File: hw/bst_test_port.v
`timescale 1ns/1ns
`include "bst_regs.vh"

module bst_test_port #(
    parameter       NOUT     = 4,          // Output cells 172..169
    parameter       NIN      = 169,        // Input cells 168..0
    parameter [10:0] MFG_ID  = 11'h0aa,    // Arbitrary value
    parameter [15:0] PART_ID = 16'h1234,   // Arbitrary value
    parameter [3:0] VERSION  = 4'h0        // Arbitrary value
) (
    input  wire            clock_i,        // 25 MHz system clock
    input  wire            rstn_i,         // Async reset, active low
    input  wire            tck_i,          // Test clock pin
    input  wire            tms_i,          // Test mode select pin
    input  wire            tdi_i,          // Test data in pin
    output reg             tdo_o,          // Test data out
    output reg             tdo_oe_o,       // Test data out enable
    input  wire            float_ctl_i,    // output_float_control_input pin
    input  wire [NIN-1:0]  pin_in_i,       // Other observed input pins
    input  wire [NOUT-1:0] core_out_i,     // Core values for output pins
    input  wire [NOUT-1:0] core_oe_i,      // Core enables for output pins
    output wire [NOUT-1:0] pin_out_o,      // Output pin values
    output wire [NOUT-1:0] pin_oe_o        // Output pin enables
);
    localparam LEN = NOUT + NIN + 1;

    // ----------------------------------------
    // Pin synchronisers and test clock edges
    // ----------------------------------------
    reg [3:0] sync1;
    reg [3:0] sync2;
    reg       tck_prev;
    wire      tck_s = sync2[0];
    wire      tms_s = sync2[1];
    wire      tdi_s = sync2[2];
    wire      rise  = tck_s & ~tck_prev;
    wire      fall  = ~tck_s & tck_prev;

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1    <= 4'h0;
            sync2    <= 4'h0;
            tck_prev <= 1'b0;
        end else begin
            sync1    <= {float_ctl_i, tdi_i, tms_i, tck_i};
            sync2    <= sync1;
            tck_prev <= sync2[0];
        end
    end

    // ----------------------------------------
    // Controller
    // ----------------------------------------
    reg [`BST_ST_W-1:0] state;
    reg [`BST_ST_W-1:0] next_state;

    always @* begin
        case (state)
            `BST_ST_RESET:  next_state = tms_s ? `BST_ST_RESET  : `BST_ST_IDLE;
            `BST_ST_IDLE:   next_state = tms_s ? `BST_ST_SEL_DR : `BST_ST_IDLE;
            `BST_ST_SEL_DR: next_state = tms_s ? `BST_ST_SEL_IR : `BST_ST_CAP_DR;
            `BST_ST_CAP_DR: next_state = tms_s ? `BST_ST_EX1_DR : `BST_ST_SH_DR;
            `BST_ST_SH_DR:  next_state = tms_s ? `BST_ST_EX1_DR : `BST_ST_SH_DR;
            `BST_ST_EX1_DR: next_state = tms_s ? `BST_ST_UPD_DR : `BST_ST_PA_DR;
            `BST_ST_PA_DR:  next_state = tms_s ? `BST_ST_EX2_DR : `BST_ST_PA_DR;
            `BST_ST_EX2_DR: next_state = tms_s ? `BST_ST_UPD_DR : `BST_ST_SH_DR;
            `BST_ST_UPD_DR: next_state = tms_s ? `BST_ST_SEL_DR : `BST_ST_IDLE;
            `BST_ST_SEL_IR: next_state = tms_s ? `BST_ST_RESET  : `BST_ST_CAP_IR;
            `BST_ST_CAP_IR: next_state = tms_s ? `BST_ST_EX1_IR : `BST_ST_SH_IR;
            `BST_ST_SH_IR:  next_state = tms_s ? `BST_ST_EX1_IR : `BST_ST_SH_IR;
            `BST_ST_EX1_IR: next_state = tms_s ? `BST_ST_UPD_IR : `BST_ST_PA_IR;
            `BST_ST_PA_IR:  next_state = tms_s ? `BST_ST_EX2_IR : `BST_ST_PA_IR;
            `BST_ST_EX2_IR: next_state = tms_s ? `BST_ST_UPD_IR : `BST_ST_SH_IR;
            `BST_ST_UPD_IR: next_state = tms_s ? `BST_ST_SEL_DR : `BST_ST_IDLE;
            default:        next_state = `BST_ST_RESET;
        endcase
    end

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= `BST_ST_RESET;
        end else if (rise) begin
            state <= next_state;
        end
    end

    // Actions happen on the rising edge that leaves the named state
    wire cap_dr = rise & (state == `BST_ST_CAP_DR);
    wire sh_dr  = rise & (state == `BST_ST_SH_DR);
    wire cap_ir = rise & (state == `BST_ST_CAP_IR);
    wire sh_ir  = rise & (state == `BST_ST_SH_IR);
    // Update takes effect on the falling edge inside the update state
    wire upd_dr = fall & (state == `BST_ST_UPD_DR);
    wire upd_ir = fall & (state == `BST_ST_UPD_IR);

    // ----------------------------------------
    // Instruction register
    // ----------------------------------------
    reg [`BST_IR_WIDTH-1:0] ir_shift;
    reg [`BST_IR_WIDTH-1:0] instruction_holding_register;

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ir_shift                     <= `BST_IR_CAPTURE;
            instruction_holding_register <= `BST_IR_RESET_VAL;
        end else begin
            if (cap_ir) begin
                ir_shift <= `BST_IR_CAPTURE;
            end else if (sh_ir) begin
                ir_shift <= {tdi_s, ir_shift[`BST_IR_WIDTH-1:1]};
            end
            if (fall && state == `BST_ST_RESET) begin
                instruction_holding_register <= `BST_IR_RESET_VAL;
            end else if (upd_ir) begin
                instruction_holding_register <= ir_shift;
            end
        end
    end

    wire [`BST_IR_WIDTH-1:0] ir = instruction_holding_register;
    wire sel_chain = (ir == `BST_IR_EXTEST) | (ir == `BST_IR_SAMPLE);
    wire sel_id    = (ir == `BST_IR_IDCODE);
    wire test_mode = (ir == `BST_IR_EXTEST) | (ir == `BST_IR_CLAMP);
    wire float_all = (ir == `BST_IR_HIGHZ);

    // ----------------------------------------
    // Identification and bypass
    // ----------------------------------------
    wire [`BST_ID_WIDTH-1:0] id_value = {VERSION, PART_ID, MFG_ID, 1'b1};
    reg  [`BST_ID_WIDTH-1:0] identification_word_register;
    reg                      single_bit_bypass_stage;

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            identification_word_register <= {`BST_ID_WIDTH{1'b0}};
            single_bit_bypass_stage      <= 1'b0;
        end else begin
            if (cap_dr && sel_id) begin
                identification_word_register <= id_value;
            end else if (sh_dr && sel_id) begin
                identification_word_register <=
                    {tdi_s, identification_word_register[`BST_ID_WIDTH-1:1]};
            end
            if (cap_dr) begin
                single_bit_bypass_stage <= 1'b0;
            end else if (sh_dr) begin
                single_bit_bypass_stage <= tdi_s;
            end
        end
    end

    // ----------------------------------------
    // Boundary chain: bit LEN-1 is cell 173
    // ----------------------------------------
    wire [LEN-1:0] cell_latch;
    wire           chain_out;
    reg  [NIN-1:0] pin_in_meta;
    reg  [NIN-1:0] pin_in_sync;

    // Each pin synchronised alone; pins that move together may be caught apart
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_in_meta <= {NIN{1'b0}};
            pin_in_sync <= {NIN{1'b0}};
        end else begin
            pin_in_meta <= pin_in_i;
            pin_in_sync <= pin_in_meta;
        end
    end

    // Output cells capture what the pins actually carry
    wire [LEN-1:0] cell_pins = {sync2[3], pin_out_o, pin_in_sync};

    bst_cell_chain #(
        .LEN(LEN)
    ) u_chain (
        .clock_i   (clock_i),
        .rstn_i    (rstn_i),
        .capture_i (cap_dr & sel_chain),
        .shift_i   (sh_dr & sel_chain),
        .update_i  (upd_dr & sel_chain),
        .sin_i     (tdi_s),
        .pins_i    (cell_pins),
        .sout_o    (chain_out),
        .latch_o   (cell_latch)
    );

    // Output cells drive pins only in extest or clamp, where every enable is forced on,
    // since the chain holds no separate enable cells for these outputs.
    wire [NOUT-1:0] bs_out = cell_latch[NIN +: NOUT];
    assign pin_out_o = test_mode ? bs_out : core_out_i;
    assign pin_oe_o  = float_all ? {NOUT{1'b0}} :
                       (test_mode ? {NOUT{1'b1}} : core_oe_i);

    // ----------------------------------------
    // Serial output, falling test clock
    // ----------------------------------------
    reg serial_sel;
    always @* begin
        if (state == `BST_ST_SH_IR) begin
            serial_sel = ir_shift[0];
        end else if (sel_chain) begin
            serial_sel = chain_out;
        end else if (sel_id) begin
            serial_sel = identification_word_register[0];
        end else begin
            serial_sel = single_bit_bypass_stage;
        end
    end

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (fall) begin
            tdo_o    <= serial_sel;
            tdo_oe_o <= (state == `BST_ST_SH_DR) | (state == `BST_ST_SH_IR);
        end
    end
endmodule

// File: hw/bst_regs.vh
`ifndef BST_REGS_VH
`define BST_REGS_VH

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define BST_IR_WIDTH      3
`define BST_IR_EXTEST     3'h0
`define BST_IR_IDCODE     3'h1
`define BST_IR_SAMPLE     3'h2
`define BST_IR_CLAMP      3'h3
`define BST_IR_HIGHZ      3'h6
`define BST_IR_MFG        3'h5
`define BST_IR_BYPASS     3'h7
`define BST_IR_RESET_VAL  3'h1
`define BST_IR_CAPTURE    3'h1

// ----------------------------------------
// Identification word layout
// ----------------------------------------
`define BST_ID_WIDTH      32
`define BST_ID_FIXED_BIT  0
`define BST_ID_MFG_LSB    1
`define BST_ID_MFG_MSB    11
`define BST_ID_PART_LSB   12
`define BST_ID_PART_MSB   27
`define BST_ID_VER_LSB    28
`define BST_ID_VER_MSB    31

// ----------------------------------------
// Boundary chain
// ----------------------------------------
`define BST_CHAIN_LEN     174
`define BST_CELL_FLOAT    173

// ----------------------------------------
// Controller states (one-hot, 16 states)
// ----------------------------------------
`define BST_ST_W          16
`define BST_ST_RESET      16'h0001
`define BST_ST_IDLE       16'h0002
`define BST_ST_SEL_DR     16'h0004
`define BST_ST_CAP_DR     16'h0008
`define BST_ST_SH_DR      16'h0010
`define BST_ST_EX1_DR     16'h0020
`define BST_ST_PA_DR      16'h0040
`define BST_ST_EX2_DR     16'h0080
`define BST_ST_UPD_DR     16'h0100
`define BST_ST_SEL_IR     16'h0200
`define BST_ST_CAP_IR     16'h0400
`define BST_ST_SH_IR      16'h0800
`define BST_ST_EX1_IR     16'h1000
`define BST_ST_PA_IR      16'h2000
`define BST_ST_EX2_IR     16'h4000
`define BST_ST_UPD_IR     16'h8000

`endif

// File: hw/bst_cell_chain.v
`timescale 1ns/1ns
`include "bst_regs.vh"

// ----------------------------------------
// Boundary chain: shift stage plus update latch per cell
// ----------------------------------------
module bst_cell_chain #(
    parameter LEN = `BST_CHAIN_LEN
) (
    input  wire           clock_i,    // System clock
    input  wire           rstn_i,     // Async reset, active low
    input  wire           capture_i,  // Capture pulse
    input  wire           shift_i,    // Shift pulse
    input  wire           update_i,   // Update pulse
    input  wire           sin_i,      // Serial in
    input  wire [LEN-1:0] pins_i,     // Parallel sample
    output wire           sout_o,     // Serial out, cell 0
    output reg  [LEN-1:0] latch_o     // Latched parallel outputs
);
    reg [LEN-1:0] stage;

    assign sout_o = stage[0];

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stage   <= {LEN{1'b0}};
            latch_o <= {LEN{1'b0}};
        end else begin
            if (capture_i) begin
                stage <= pins_i;
            end else if (shift_i) begin
                stage <= {sin_i, stage[LEN-1:1]};
            end
            if (update_i) begin
                latch_o <= stage;
            end
        end
    end
endmodule

// File: sim/bst_tester.sv
`timescale 1ns/1ns

// ----------------------------------------
// Test controller model
// ----------------------------------------
module bst_tester (
    input  wire  clock_i, // System clock
    input  wire  tdo_i,   // Resolved serial out
    output logic tck_o,   // Test clock, still between steps
    output logic tms_o,   // Mode select
    output logic tdi_o    // Serial data to device
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // One test clock period: 5 low, 3 high cycles; call right after a clock edge
    task automatic step(input logic m, input logic d, output logic q);
        tms_o <= m;
        tdi_o <= d;
        repeat (5) @(posedge clock_i);
        q = tdo_i;
        tck_o <= 1'b1;
        repeat (3) @(posedge clock_i);
        tck_o <= 1'b0;
    endtask
endmodule

// File: sim/bst_test_port_chk.sv
`timescale 1ns/1ns

// ----------------------------------------
// Port checker
// ----------------------------------------
module bst_test_port_chk #(
    parameter NOUT = 4
) (
    input wire logic            clock_i,    // System clock
    input wire logic            rstn_i,     // Async reset
    input wire logic            tck_i,      // Test clock
    input wire logic            tdo_o,      // Serial out
    input wire logic            tdo_oe_o,   // Serial out enable
    input wire logic [NOUT-1:0] core_out_i, // Core values
    input wire logic [NOUT-1:0] core_oe_i,  // Core enables
    input wire logic [NOUT-1:0] pin_out_o,  // Pin values
    input wire logic [NOUT-1:0] pin_oe_o    // Pin enables
);
    logic       tck_q;
    logic [1:0] rises;

    // Shift states need at least three test clock rises after reset
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tck_q <= 1'b0;
            rises <= 2'h0;
        end else begin
            tck_q <= tck_i;
            if (tck_i && !tck_q && rises != 2'h3)
                rises <= rises + 2'h1;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    tdo_edge_a: assert property ($changed(tdo_o) |-> !$past(tck_i) && !$past(tck_i, 3))
        else $error("serial out moved outside the low clock phase");
    tdo_hold_a: assert property ($changed(tdo_o) |=> $stable(tdo_o) [*5])
        else $error("serial out did not hold for a test clock");
    oe_after_clk_a: assert property (tdo_oe_o |-> rises == 2'h3)
        else $error("serial out enabled too early");
    oe_min_len_a: assert property ($rose(tdo_oe_o) |=> tdo_oe_o [*6])
        else $error("serial out enable too short");
    pin_oe_set_a: assert property (pin_oe_o == '0 || pin_oe_o == '1 || pin_oe_o == core_oe_i)
        else $error("pin enables out of range");
    pin_out_cause_a: assert property ($changed(pin_out_o) && $stable(core_out_i) |-> !$past(tck_i))
        else $error("pin values moved without a falling test clock");
    pin_oe_cause_a: assert property ($changed(pin_oe_o) && $stable(core_oe_i) |-> !$past(tck_i))
        else $error("pin enables moved without a falling test clock");
    reset_pins_a: assert property ($rose(rstn_i) |-> pin_out_o == core_out_i && pin_oe_o == core_oe_i)
        else $error("pins not following core after reset");

    cover property ($rose(tdo_oe_o));
    cover property (pin_oe_o == '0);
    cover property (pin_out_o != core_out_i);
endmodule

bind bst_test_port bst_test_port_chk #(.NOUT(NOUT)) u_bst_test_port_chk (
    .clock_i(clock_i), .rstn_i(rstn_i), .tck_i(tck_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
    .core_out_i(core_out_i), .core_oe_i(core_oe_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

// File: sim/bst_test_port_tb_top.sv
`timescale 1ns/1ns
`include "bst_regs.vh"

// ----------------------------------------
// Bench top
// ----------------------------------------
module bst_test_port_tb_top;
    localparam logic [10:0]  MFG  = 11'h155;   // Arbitrary value
    localparam logic [15:0]  PART = 16'h2b3c;  // Arbitrary value
    localparam logic [3:0]   VER  = 4'h5;      // Arbitrary value
    localparam logic [168:0] PAT  = {13{13'h1a5b}};
    logic         clock_i = 1'b0;
    logic         rstn_i;
    logic         float_ctl;
    logic [168:0] pin_in;
    logic [3:0]   core_out, core_oe, pin_out, pin_oe;
    logic         tck, tms, tdi, tdo, tdo_oe;
    wire          tdo_pin = tdo_oe ? tdo : 1'b1; // Pulled up while released
    int           num_errors = 0;
    int           n_compared = 0;
    logic [173:0] dout;

    always #20 clock_i = ~clock_i;

    bst_test_port #(.MFG_ID(MFG), .PART_ID(PART), .VERSION(VER)) u_bst_test_port (
        .clock_i(clock_i), .rstn_i(rstn_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .float_ctl_i(float_ctl), .pin_in_i(pin_in),
        .core_out_i(core_out), .core_oe_i(core_oe), .pin_out_o(pin_out), .pin_oe_o(pin_oe));
    bst_tester u_bst_tester (
        .clock_i(clock_i), .tdo_i(tdo_pin), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

    task automatic chk(input logic [173:0] got, input logic [173:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    // Data line toggles while not shifting
    task automatic tms_seq(input logic [7:0] s, input int n);
        logic q;
        for (int i = 0; i < n; i++) u_bst_tester.step(s[i], i[0], q);
    endtask

    task automatic load_ir(input logic [2:0] code);
        logic [2:0] cap;
        tms_seq(8'h03, 4);
        for (int i = 0; i < 3; i++) u_bst_tester.step(i == 2, code[i], cap[i]);
        tms_seq(8'h01, 2);
        chk(cap, 3'b001, "instruction capture");
    endtask

    task automatic shift_dr(input int n, input logic [173:0] din);
        dout = '0;
        tms_seq(8'h01, 3);
        for (int i = 0; i < n; i++) u_bst_tester.step(i == n - 1, din[i], dout[i]);
        tms_seq(8'h01, 2);
        chk(tdo_oe, 1'b0, "serial out not released after shift");
    endtask

    task automatic s_idcode;
        shift_dr(32, '1);
        chk(dout[31:0], {VER, PART, MFG, 1'b1}, "identification word");
    endtask

    task automatic s_bypass;
        for (int k = 0; k < 2; k++) begin
            // Unused code 100 stands in for a reserved one; the tester never loads 101
            load_ir(k ? 3'h4 : `BST_IR_BYPASS);
            shift_dr(8, 8'hb4);
            chk(dout[7:0], 8'h68, "bypass path");
        end
    endtask

    task automatic s_scan;
        load_ir(`BST_IR_SAMPLE);
        chk({pin_out, pin_oe}, {core_out, core_oe}, "sample pass-through");
        shift_dr(174, {1'b0, 4'h6, 169'h0});
        chk(dout, {1'b1, 4'h9, PAT}, "sample capture");
        chk({pin_out, pin_oe}, {core_out, core_oe}, "preload keeps pins");
        load_ir(`BST_IR_EXTEST);
        chk({pin_out, pin_oe}, 8'h6f, "preloaded pattern driven");
        float_ctl <= 1'b0;
        shift_dr(174, {1'b0, 4'h9, 169'h0});
        chk(dout, {1'b0, 4'h6, PAT}, "external test capture");
        chk(pin_out, 4'h9, "external test update");
        load_ir(`BST_IR_CLAMP);
        shift_dr(4, 4'h5);
        chk({pin_out, pin_oe, dout[3:0]}, 12'h9fa, "clamp");
        load_ir(`BST_IR_HIGHZ);
        chk(pin_oe, 4'h0, "high impedance");
        load_ir(`BST_IR_BYPASS);
        chk({pin_out, pin_oe}, {core_out, core_oe}, "pins back to core");
    endtask

    // Controller reset by mode select, then an asynchronous reset in mid-run
    task automatic s_reset;
        load_ir(`BST_IR_EXTEST);
        tms_seq(8'h1f, 6);
        chk({pin_out, pin_oe}, {core_out, core_oe}, "controller reset");
        s_idcode();
        load_ir(`BST_IR_CLAMP);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk({pin_out, pin_oe}, {core_out, core_oe}, "pins after reset");
        tms_seq(8'h00, 1);
        s_idcode();
    endtask

    task automatic results;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        rstn_i <= 1'b0;
        float_ctl <= 1'b1;
        pin_in <= PAT;
        core_out <= 4'h9;
        core_oe <= 4'h6;
        repeat (8) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        tms_seq(8'h1f, 6);
        s_idcode();
        s_bypass();
        s_scan();
        s_reset();
        results();
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge clock_i);
        num_errors++;
        results();
    end
endmodule
